// ---- rtl/sfw_ctrl.sv ----
/*
 Serial flash write controller: register block, clock divider and a
 sequencer that shifts command words and 128-bit data blocks to the flash.
 Assumes a synchronous word register port and flash pins synchronised here.
*/
// Contract
// RULE1: Control bit 0 starts the flash write; resets to zero.
// RULE2: Control bits 4:1 hold the serial clock divider, reset 4'b0001.
// RULE3: Control bit 5 stops the write in progress.
// RULE4: Control bits 7 and 8 pick single or four device writes; the code decodes bit 8 only and bit 7 has no effect.
// RULE5: Count register gives number of 128-bit blocks, resets zero.
// RULE6: Four 32-bit data registers hold host write data, reset zero.
// RULE7: Host sets data-valid; controller clears it after taking data.
// RULE8: Host sets command-valid after loading a command word.
// RULE9: Configuration bits 8:2 give command length in bits, reset 0x8.
// RULE10: Configuration bits 15:9 give data length in bits.
// RULE11: Bit 16 requests new data, resets one, cleared on capture.
// RULE12: Status bits 4:0 show sequencer state, reset zero.
// RULE13: Status bits 5 and 6 flag read done and write done.
// RULE14: Status bit 7 flags a CRC read error.
// RULE15: Status bit 8 flags a write error from flash status.
// RULE16: Current read address and fallback address have own registers.
// RULE17: All writes use a single data line per device.
// RULE18: Host reaches registers indirectly through PCIe or JTAG.
// RULE19: Command and data words shift most significant bit first.
// RULE20: Data words join into one block, one block per handshake.
// RULE21: Up to four command words shift before the block data.
// RULE22: Control bit 6 pauses the sequencer; clearing resumes it.
`timescale 1ns/1ps
module sfw_ctrl
   import sfw_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rstn,
   // Register port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_addr,
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] reg_rdata,
   // Events and addresses from the read side
   input  wire logic        read_done,
   input  wire logic        read_crc_err,
   input  wire logic [31:0] cur_read_addr,
   // Flash pins
   input  wire logic        flash_status_err,
   output logic             flash_sck,
   output logic             flash_cs_n,
   output logic      [3:0]  flash_so
);

   typedef struct packed {
      logic [31:0]  ctrl;
      logic [31:0]  count;
      logic [127:0] data;
      logic [127:0] cmd;
      logic         dv;
      logic         cv;
      logic [6:0]   cc;
      logic [6:0]   dc;
      logic         req;
      logic         rdone;
      logic         wdone;
      logic         rerr;
      logic         werr;
      logic [31:0]  fb;
      sfw_state_t   st;
      logic [127:0] shreg;
      logic [1:0]   cidx;
      logic [6:0]   bit_n;
      logic [31:0]  blocks;
      logic [3:0]   div;
      logic         sck;
      logic         cs_n;
      logic         so;
      logic [3:0]   lanes;
      logic [31:0]  rdata;
      logic [2:0]   esync;
   } sfw_reg_t;

   sfw_reg_t q, d;
   logic     tick;
   logic     err_pin;

   // Full 32-bit word from a packed 128-bit group, word 0 uppermost.
   function automatic logic [31:0] word_of(input logic [127:0] v,
                                           input logic [1:0]   i);
      word_of = v[(3 - i) * 32 +: 32];
   endfunction : word_of

   // One bit of command word i, counted up from its least significant bit.
   function automatic logic cmd_bit(input logic [127:0] v,
                                    input logic [1:0]   i,
                                    input logic [6:0]   n);
      logic [31:0] w;
      w = word_of(v, i);
      cmd_bit = w[n[4:0]];
   endfunction : cmd_bit

   assign err_pin = q.esync[2] & q.esync[1];
   assign tick    = q.div == q.ctrl[SFW_CTRL_DIV_H:SFW_CTRL_DIV_L];

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      d = q;
      // Divider: an enable pulse every div+1 cycles halves into sck.
      d.div = tick ? 4'h0 : 4'(q.div + 4'h1); // see RULE2
      d.esync = {q.esync[1:0], flash_status_err};
      if (read_done) begin
         d.rdone = 1'b1; // see RULE13
      end
      if (read_crc_err) begin
         d.rerr = 1'b1; // see RULE14
      end
      // Register writes; the host reaches these via its port bridge.
      if (reg_wr) begin // see RULE18
         unique case (reg_addr)
            SFW_OFF_CTRL:   d.ctrl = {23'h0, reg_wdata[8:0]};
            SFW_OFF_COUNT:  d.count = reg_wdata; // see RULE5
            SFW_OFF_DAT1:   d.data[127:96] = reg_wdata; // see RULE6
            SFW_OFF_DAT2:   d.data[95:64] = reg_wdata;
            SFW_OFF_DAT3:   d.data[63:32] = reg_wdata;
            SFW_OFF_DAT4:   d.data[31:0] = reg_wdata;
            SFW_OFF_CMD1:   d.cmd[127:96] = reg_wdata;
            SFW_OFF_CMD2:   d.cmd[95:64] = reg_wdata;
            SFW_OFF_CMD3:   d.cmd[63:32] = reg_wdata;
            SFW_OFF_CMD4:   d.cmd[31:0] = reg_wdata;
            SFW_OFF_FBADDR: d.fb = reg_wdata; // see RULE16
            SFW_OFF_CFG: begin
               d.dv = reg_wdata[SFW_CFG_DV]; // see RULE7
               d.cv = reg_wdata[SFW_CFG_CV]; // see RULE8
               d.cc = reg_wdata[SFW_CFG_CC_H:SFW_CFG_CC_L]; // see RULE9
               d.dc = reg_wdata[SFW_CFG_DC_H:SFW_CFG_DC_L]; // see RULE10
            end
            default: ;
         endcase
      end
      // Sequencer, stepped on falling sck edges so data is stable on rise.
      if (q.ctrl[SFW_CTRL_STOP] && q.st != SFW_IDLE) begin
         d.st = SFW_IDLE; // see RULE3
         d.cs_n = 1'b1;
         d.sck = 1'b0;
      end else if (tick && !q.ctrl[SFW_CTRL_WAIT]) begin // see RULE22
         unique case (q.st)
            SFW_IDLE: begin
               // A set stop bit also holds off any restart.
               if (q.ctrl[SFW_CTRL_EN] && !q.ctrl[SFW_CTRL_STOP] &&
                   q.count != 32'h0) begin // see RULE1
                  d.st = SFW_WAIT_DATA;
                  d.blocks = 32'h0;
                  d.wdone = 1'b0;
               end
            end
            SFW_WAIT_DATA: begin
               if (q.dv && q.cv) begin
                  d.shreg = q.data; // see RULE20
                  // A host write of the handshake in this cycle wins.
                  if (!(reg_wr && reg_addr == SFW_OFF_CFG)) begin
                     d.dv = 1'b0; // see RULE7
                  end
                  d.req = 1'b0; // see RULE11
                  d.cidx = 2'h0;
                  d.bit_n = q.cc;
                  d.st = SFW_SEND_CMD;
                  d.cs_n = 1'b0;
                  d.so = cmd_bit(q.cmd, 2'h0, q.cc); // see RULE19
               end
            end
            SFW_SEND_CMD: begin
               d.sck = ~q.sck;
               if (q.sck) begin
                  if (q.bit_n == 7'h0) begin
                     if (q.cidx == 2'h3) begin // see RULE21
                        d.bit_n = q.dc;
                        d.st = SFW_SEND_DATA;
                     end else begin
                        d.cidx = 2'(q.cidx + 2'h1);
                        d.bit_n = q.cc;
                     end
                  end else begin
                     d.bit_n = 7'(q.bit_n - 7'h1);
                  end
               end
               // Next bit of the current command, or the first data bit.
               if (d.st == SFW_SEND_DATA) begin
                  d.so = q.shreg[127];
               end else begin
                  d.so = cmd_bit(q.cmd, d.cidx, d.bit_n); // see RULE19
               end
            end
            SFW_SEND_DATA: begin
               d.sck = ~q.sck;
               if (q.sck) begin
                  d.shreg = {q.shreg[126:0], 1'b0}; // see RULE19
                  if (q.bit_n == 7'h0) begin
                     d.st = SFW_NEXT;
                     d.cs_n = 1'b1;
                     d.sck = 1'b0;
                  end else begin
                     d.bit_n = 7'(q.bit_n - 7'h1);
                  end
               end
               d.so = d.shreg[127]; // see RULE17
            end
            SFW_NEXT: begin
               d.blocks = 32'(q.blocks + 32'h1);
               d.req = 1'b1; // see RULE11
               d.st = (32'(q.blocks + 32'h1) >= q.count) ? SFW_DONE
                                                           : SFW_WAIT_DATA;
            end
            SFW_DONE: begin
               d.wdone = 1'b1; // see RULE13
               if (!(reg_wr && reg_addr == SFW_OFF_CTRL)) begin
                  d.ctrl[SFW_CTRL_EN] = 1'b0;
               end
               d.st = SFW_IDLE;
            end
            default: d.st = SFW_IDLE;
         endcase
      end
      if (err_pin && q.st != SFW_IDLE) begin
         d.werr = 1'b1; // see RULE15
      end
      // Four-device mode copies the serial bit onto every device line.
      d.lanes = d.ctrl[SFW_CTRL_X4] ? {4{d.so}} : {3'h0, d.so}; // see RULE4
      // Read mux, registered so reg_rdata comes from a flip-flop.
      d.rdata = 32'h0;
      if (reg_rd) begin
         unique case (reg_addr)
            SFW_OFF_CTRL:    d.rdata = q.ctrl;
            SFW_OFF_COUNT:   d.rdata = q.count;
            SFW_OFF_DAT1:    d.rdata = word_of(q.data, 2'h0);
            SFW_OFF_DAT2:    d.rdata = word_of(q.data, 2'h1);
            SFW_OFF_DAT3:    d.rdata = word_of(q.data, 2'h2);
            SFW_OFF_DAT4:    d.rdata = word_of(q.data, 2'h3);
            SFW_OFF_CMD1:    d.rdata = word_of(q.cmd, 2'h0);
            SFW_OFF_CMD2:    d.rdata = word_of(q.cmd, 2'h1);
            SFW_OFF_CMD3:    d.rdata = word_of(q.cmd, 2'h2);
            SFW_OFF_CMD4:    d.rdata = word_of(q.cmd, 2'h3);
            SFW_OFF_CFG:     d.rdata = {15'h0, q.req, q.dc, q.cc, q.cv, q.dv};
            SFW_OFF_STAT:    d.rdata = {23'h0, q.werr, q.rerr, q.wdone,
                                        q.rdone, q.st}; // see RULE12
            SFW_OFF_FBADDR:  d.rdata = q.fb;
            SFW_OFF_CURADDR: d.rdata = cur_read_addr; // see RULE16
            default:         d.rdata = 32'h0;
         endcase
      end
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
         q.ctrl[SFW_CTRL_DIV_H:SFW_CTRL_DIV_L] <= SFW_DIV_RST; // see RULE2
         q.cc <= SFW_CC_RST;
         q.dc <= SFW_DC_RST;
         q.req <= 1'b1;
         q.cs_n <= 1'b1;
         q.st <= SFW_IDLE;
      end else begin
         q <= d;
      end
   end

   always_comb begin
      reg_rdata = q.rdata;
      flash_sck = q.sck;
      flash_cs_n = q.cs_n;
      flash_so = q.lanes;
   end

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   start_seq_a: assert property ( // see RULE1
      q.st == SFW_IDLE && tick && q.ctrl[SFW_CTRL_EN] &&
      !q.ctrl[SFW_CTRL_STOP] && !q.ctrl[SFW_CTRL_WAIT] && q.count != 32'h0
      |=> q.st == SFW_WAIT_DATA)
      else $error("write did not start");
   stop_idle_a: assert property ( // see RULE3
      q.ctrl[SFW_CTRL_STOP] && q.st != SFW_IDLE
      |=> q.st == SFW_IDLE && flash_cs_n)
      else $error("stop did not abort");
   dv_clear_a: assert property ( // see RULE7
      q.st == SFW_WAIT_DATA && d.st == SFW_SEND_CMD &&
      !(reg_wr && reg_addr == SFW_OFF_CFG) |=> !q.dv && !q.req)
      else $error("data valid not cleared");
   wait_hold_a: assert property ( // see RULE22
      q.ctrl[SFW_CTRL_WAIT] && !q.ctrl[SFW_CTRL_STOP]
      |=> $stable(q.st) && $stable(q.bit_n))
      else $error("wait did not hold");
   div_period_a: assert property ( // see RULE2
      tick && !reg_wr && q.ctrl[SFW_CTRL_DIV_H:SFW_CTRL_DIV_L] == 4'h1
      ##1 !reg_wr |-> !tick ##1 tick)
      else $error("divider pulse misplaced");
   so_lanes_a: assert property ( // see RULE4
      !q.ctrl[SFW_CTRL_X4] |-> flash_so[3:1] == 3'h0)
      else $error("extra lanes driven");
   stat_read_a: assert property ( // see RULE12
      reg_rd && reg_addr == SFW_OFF_STAT |=> reg_rdata[4:0] == $past(q.st))
      else $error("status state wrong");
   wdone_set_a: assert property ( // see RULE13
      q.st == SFW_DONE && tick && !q.ctrl[SFW_CTRL_WAIT] &&
      !q.ctrl[SFW_CTRL_STOP] |=> q.wdone && q.st == SFW_IDLE)
      else $error("write done missing");
   msb_first_a: assert property ( // see RULE19
      q.st == SFW_SEND_DATA && tick && q.sck && !q.ctrl[SFW_CTRL_WAIT] &&
      !q.ctrl[SFW_CTRL_STOP] |=> q.shreg[127] == $past(q.shreg[126]))
      else $error("data not msb first");
   werr_set_a: assert property ( // see RULE15
      err_pin && q.st != SFW_IDLE |=> q.werr)
      else $error("write error lost");

   block_c: cover property (q.st == SFW_NEXT);
   done_c:  cover property (q.st == SFW_DONE);
   stop_c:  cover property (q.ctrl[SFW_CTRL_STOP] && q.st == SFW_SEND_DATA);

endmodule : sfw_ctrl

// ---- rtl/sfw_pkg.sv ----
/*
 Constants for the serial flash write controller: register offsets, field
 positions, reset values and state codes.
 Assumes a word-wide register port with byte offsets as printed.
*/
package sfw_pkg;

   // ==========================================================
   // Register offsets
   // ==========================================================
   localparam logic [15:0] SFW_OFF_CTRL   = 16'h1038;
   localparam logic [15:0] SFW_OFF_CMD1   = 16'h103c;
   localparam logic [15:0] SFW_OFF_DAT1   = 16'h1040;
   localparam logic [15:0] SFW_OFF_DAT4   = 16'h1044;
   localparam logic [15:0] SFW_OFF_COUNT  = 16'h1048;
   localparam logic [15:0] SFW_OFF_CMD2   = 16'h104c;
   localparam logic [15:0] SFW_OFF_CFG    = 16'h1050;
   localparam logic [15:0] SFW_OFF_CMD3   = 16'h1054;
   localparam logic [15:0] SFW_OFF_CMD4   = 16'h1058;
   localparam logic [15:0] SFW_OFF_STAT   = 16'h1060;
   localparam logic [15:0] SFW_OFF_DAT2   = 16'h11d4;
   localparam logic [15:0] SFW_OFF_DAT3   = 16'h11d8;
   localparam logic [15:0] SFW_OFF_FBADDR = 16'h12b8;
   localparam logic [15:0] SFW_OFF_CURADDR = 16'h12bc;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int SFW_CTRL_EN    = 0;
   localparam int SFW_CTRL_DIV_L = 1;
   localparam int SFW_CTRL_DIV_H = 4;
   localparam int SFW_CTRL_STOP  = 5;
   localparam int SFW_CTRL_WAIT  = 6;
   localparam int SFW_CTRL_X1    = 7;
   localparam int SFW_CTRL_X4    = 8;
   localparam int SFW_CFG_DV     = 0;
   localparam int SFW_CFG_CV     = 1;
   localparam int SFW_CFG_CC_L   = 2;
   localparam int SFW_CFG_CC_H   = 8;
   localparam int SFW_CFG_DC_L   = 9;
   localparam int SFW_CFG_DC_H   = 15;
   localparam int SFW_CFG_REQ    = 16;
   localparam int SFW_ST_RDONE   = 5;
   localparam int SFW_ST_WDONE   = 6;
   localparam int SFW_ST_RERR    = 7;
   localparam int SFW_ST_WERR    = 8;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [3:0] SFW_DIV_RST = 4'h1;
   localparam logic [6:0] SFW_CC_RST  = 7'h08;
   // Printed as 0x127; only the low seven bits fit the field.
   localparam logic [6:0] SFW_DC_RST  = 7'h27;

   // ==========================================================
   // Sequencer states
   // ==========================================================
   typedef enum logic [4:0] {
      SFW_IDLE,
      SFW_WAIT_DATA,
      SFW_SEND_CMD,
      SFW_SEND_DATA,
      SFW_NEXT,
      SFW_DONE
   } sfw_state_t;

endpackage : sfw_pkg

// ---- sim/sfw_flash_model.sv ----
/*
 Behavioural serial flash seen from the write side: shifts in lane 0 on
 each rising serial clock edge while selected and can report a bad status.
 Assumes the controller drives clock low between frames.
*/
`timescale 1ns/1ps
module sfw_flash_model (
   // Flash pins
   input  wire logic         flash_sck,
   input  wire logic         flash_cs_n,
   input  wire logic [3:0]   flash_so,
   output logic              flash_status_err,
   // Bench control and observation
   input  wire logic         err_inject,
   output logic      [255:0] frame_q,
   output int                bit_cnt
);
   // =======================================================
   // Capture
   // =======================================================
   initial begin
      frame_q = '0;
      bit_cnt = 0;
   end

   always @(negedge flash_cs_n) begin
      bit_cnt = 0;
   end

   // Only lane 0 is sampled, first bit lands at the top.
   always @(posedge flash_sck) begin
      if (!flash_cs_n) begin
         frame_q = {frame_q[254:0], flash_so[0]};
         bit_cnt = bit_cnt + 1;
      end
   end

   assign flash_status_err = err_inject;
endmodule : sfw_flash_model

// ---- sim/tb_top.sv ----
/*
 Self-checking bench for the flash write controller: register tasks,
 reset values, a two-block write, pause, stop and error reporting.
 Assumes the flash model in sfw_flash_model.sv.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
   fail_count++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_top
   import sfw_pkg::*;
;
   logic         clock, rstn, reg_wr, reg_rd, read_done, read_crc_err;
   logic         err_inject, flash_status_err, flash_sck, flash_cs_n, s;
   logic [15:0]  reg_addr;
   logic [31:0]  reg_wdata, reg_rdata, cur_read_addr, rv;
   logic [3:0]   flash_so;
   logic [255:0] frame_q;
   int           bit_cnt, fail_count, check_count;
   logic [31:0]  cmd [4];
   logic [31:0]  dat [4];
   logic [15:0]  cofs [4];
   logic [15:0]  dofs [4];

   sfw_ctrl dut (.clock(clock), .rstn(rstn), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .read_done(read_done),
      .read_crc_err(read_crc_err), .cur_read_addr(cur_read_addr),
      .flash_status_err(flash_status_err), .flash_sck(flash_sck),
      .flash_cs_n(flash_cs_n), .flash_so(flash_so));
   sfw_flash_model flash (.flash_sck(flash_sck), .flash_cs_n(flash_cs_n),
      .flash_so(flash_so), .flash_status_err(flash_status_err),
      .err_inject(err_inject), .frame_q(frame_q), .bit_cnt(bit_cnt));

   // =======================================================
   // Tasks
   // =======================================================
   task close_out;
      if (fail_count == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : close_out

   task wr(input logic [15:0] a, input logic [31:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clock);
      reg_wr = 1'b0;
      @(negedge clock);
   endtask : wr

   task rd(input logic [15:0] a, output logic [31:0] d);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clock);
      reg_rd = 1'b0;
      d = reg_rdata;
      @(negedge clock);
   endtask : rd

   task rc(input logic [15:0] a, input logic [31:0] e, input string n);
      rd(a, rv);
      `CHK(n, e, rv)
   endtask : rc

   task wt(input logic v);
      int n;
      n = 0;
      while (flash_cs_n !== v && n < 3000) begin
         @(negedge clock);
         n++;
      end
      `CHK("cs_n", v, flash_cs_n)
   endtask : wt

   // =======================================================
   // Clock, watchdog and tests
   // =======================================================
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   initial begin
      #(8 * 40000);
      fail_count++;
      close_out();
   end

   initial begin
      {rstn, reg_wr, reg_rd, read_done, read_crc_err, err_inject} = '0;
      reg_addr = '0;
      reg_wdata = '0;
      cur_read_addr = 32'h0bad_f00d;
      cofs = '{SFW_OFF_CMD1, SFW_OFF_CMD2, SFW_OFF_CMD3, SFW_OFF_CMD4};
      dofs = '{SFW_OFF_DAT1, SFW_OFF_DAT2, SFW_OFF_DAT3, SFW_OFF_DAT4};
      cmd = '{32'h8100_00ff, 32'h0246_8ace, 32'hf0e1_d2c3, 32'h5a5a_a5a5};
      repeat (2) @(negedge clock);
      rstn = 1'b1;
      @(negedge clock);
      rc(SFW_OFF_CTRL, 32'h0000_0002, "ctrl");
      rc(SFW_OFF_CFG, 32'h0001_4e20, "cfg");
      rc(SFW_OFF_STAT, 32'h0, "stat");
      rc(SFW_OFF_COUNT, 32'h0, "count");
      for (int i = 0; i < 4; i++) rc(dofs[i], 32'h0, "data");
      rc(16'h1000, 32'h0, "unmapped");
      for (int i = 0; i < 4; i++) wr(cofs[i], cmd[i]);
      for (int i = 0; i < 4; i++) rc(cofs[i], cmd[i], "cmd");
      wr(SFW_OFF_STAT, 32'hffff_ffff);
      rc(SFW_OFF_STAT, 32'h0, "stat_ro");
      wr(SFW_OFF_CTRL, 32'hffff_fe00);
      rc(SFW_OFF_CTRL, 32'h0, "ctrl_rsvd");
      wr(SFW_OFF_FBADDR, 32'h1234_5678);
      rc(SFW_OFF_FBADDR, 32'h1234_5678, "fallback");
      rc(SFW_OFF_CURADDR, 32'h0bad_f00d, "cur_addr");
      read_done = 1'b1;
      read_crc_err = 1'b1;
      @(negedge clock);
      {read_done, read_crc_err} = 2'b00;
      rc(SFW_OFF_STAT, 32'h0000_00a0, "rd_flags");
      wr(SFW_OFF_COUNT, 32'h2);
      rc(SFW_OFF_COUNT, 32'h2, "count_rw");
      for (int b = 0; b < 2; b++) begin
         for (int i = 0; i < 4; i++) begin
            dat[i] = (32'h1111_1111 * (i + 1)) ^ {32{b[0]}};
            wr(dofs[i], dat[i]);
         end
         rd(SFW_OFF_CFG, rv);
         `CHK("req_dv", 2'b10, {rv[16], rv[0]})
         wr(SFW_OFF_CFG, 32'h0000_fe7f);
         if (b == 0) wr(SFW_OFF_CTRL, 32'h0000_0003);
         wt(1'b0);
         wt(1'b1);
         `CHK("bits", 256, bit_cnt)
         `CHK("frame", {cmd[0], cmd[1], cmd[2], cmd[3], dat[0], dat[1],
            dat[2], dat[3]}, frame_q)
      end
      repeat (4) @(negedge clock);
      rc(SFW_OFF_STAT, 32'h0000_00e0, "done");
      rc(SFW_OFF_CTRL, 32'h0000_0002, "en_clr");
      wr(SFW_OFF_COUNT, 32'h1);
      wr(SFW_OFF_CFG, 32'h0000_fe7f);
      err_inject = 1'b1;
      wr(SFW_OFF_CTRL, 32'h0000_0103);
      wt(1'b0);
      repeat (8) @(negedge clock);
      wr(SFW_OFF_CTRL, 32'h0000_0143);
      repeat (2) @(negedge clock);
      s = flash_sck;
      repeat (20) @(negedge clock);
      `CHK("pause", {s, 1'b0}, {flash_sck, flash_cs_n})
      `CHK("x4", {4{flash_so[0]}}, flash_so)
      wr(SFW_OFF_CTRL, 32'h0000_0123);
      repeat (3) @(negedge clock);
      `CHK("stop_cs", 1'b1, flash_cs_n)
      rd(SFW_OFF_STAT, rv);
      `CHK("stop_st", 9'h1a0, rv[8:0])
      err_inject = 1'b0;
      close_out();
   end
endmodule : tb_top
